// ==== rtl/lane_sample_mapper.sv ====
// lane sample mapper: places converter samples onto sixteen lane words
// assumes samples arrive one frame per valid/ready beat from the datapath,
// and that the link layer drains lane frames with out_valid/out_ready
`include "lsm_map.svh"
`default_nettype none

// Functional notes
// - 8-bit dual, 16 lanes: a sample n on a lane n, b on b lane n; mode 51.
// - decimate-4, 4 lanes: lane 0 in-phase with first flag, lane 1 quadrature; mode 37.
// - decimate-4, 8 lanes: lanes 0,1 in-phase words, lanes 2,3 quadrature; mode 47.
// - decimate-4, 16 lanes: lanes 0-3 in-phase, 4-7 quadrature, same-index flags; mode 53.
// - decimate-8, 2 lanes: lane 0 in-phase octets 0-1, quadrature octets 2-3.
// - decimate-8, 4 lanes: lane 0 in-phase with first flag, lane 1 quadrature.
// - decimate-8, 8 lanes: lanes 0,1 in-phase, lanes 2,3 quadrature; modes 55, 58.
// - decimate-8, 16 lanes: lanes 0-3 in-phase, 4-7 quadrature, same-index flags.
// - 12-bit single, 12 lanes: even samples on a, odd on b, packed; mode 42.
// - 12-bit dual, 12 lanes: a samples on a lanes, b on b, same packing; mode 43.
module lane_sample_mapper (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [`LSM_MODE_W-1:0] link_mode_select,
    input wire logic in_valid,
    output logic in_ready,
    input wire lsm_pkg::lsm_frame_in_t in_frame,
    output logic out_valid,
    input wire logic out_ready,
    output lsm_pkg::lsm_lane_frame_t out_frame
);

    // ----
    // helpers
    // ----

    // a decimated word: fifteen sample bits then its over-range flag
    function automatic logic [`LSM_WORD_W-1:0] lsm_dec_word(
        input logic [`LSM_DEC_W-1:0] s,
        input logic f
    );
        return {s, f};
    endfunction : lsm_dec_word

    // ----
    // mode pin synchroniser
    // ----

    logic [`LSM_MODE_W-1:0] mode_s1_reg;
    logic [`LSM_MODE_W-1:0] mode_s2_reg;

    // the mode comes from pins, so two flops before any decode
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mode_s1_reg <= '0;
            mode_s2_reg <= '0;
        end else begin
            mode_s1_reg <= link_mode_select;
            mode_s2_reg <= mode_s1_reg;
        end
    end

    // ----
    // mode decode
    // ----

    wire [`LSM_MODE_W-1:0] m = mode_s2_reg;
    wire is_8b16;
    wire is_d4_4;
    wire is_d4_8;
    wire is_d4_16;
    wire is_d8_2;
    wire is_d8_4;
    wire is_d8_8;
    wire is_d8_16;
    wire is_12b_single;
    wire is_12b_dual;
    lsm_pkg::lsm_layout_t mode_layout;

    // every mode number that shares a layout decodes to the same layout
    assign is_8b16 = (m == `LSM_M8) || (m == `LSM_M51);
    assign is_d4_4 = (m == `LSM_M10) || (m == `LSM_M37);
    assign is_d4_8 = (m == `LSM_M11) || (m == `LSM_M47);
    assign is_d4_16 = (m == `LSM_M12) || (m == `LSM_M53);
    assign is_d8_2 = (m == `LSM_M13) || (m == `LSM_M39) || (m == `LSM_M56)
                  || (m == `LSM_M59) || (m == `LSM_M66) || (m == `LSM_M68);
    assign is_d8_4 = (m == `LSM_M14) || (m == `LSM_M49) || (m == `LSM_M57)
                  || (m == `LSM_M60) || (m == `LSM_M67);
    assign is_d8_8 = (m == `LSM_M15) || (m == `LSM_M55) || (m == `LSM_M58);
    assign is_d8_16 = (m == `LSM_M16);
    assign is_12b_single = (m == `LSM_M19) || (m == `LSM_M42);
    assign is_12b_dual = (m == `LSM_M20) || (m == `LSM_M43);

    // decimate-4 and decimate-8 share lane layouts at 4, 8 and 16 lanes
    assign mode_layout =
        is_8b16 ? lsm_pkg::LSM_LAY_8B_DUAL16 :
        (is_d4_4 || is_d8_4) ? lsm_pkg::LSM_LAY_DEC_4 :
        (is_d4_8 || is_d8_8) ? lsm_pkg::LSM_LAY_DEC_8 :
        (is_d4_16 || is_d8_16) ? lsm_pkg::LSM_LAY_DEC_16 :
        is_d8_2 ? lsm_pkg::LSM_LAY_DEC8_2 :
        (is_12b_single || is_12b_dual) ? lsm_pkg::LSM_LAY_12B_12 :
        lsm_pkg::LSM_LAY_NONE;

    // ----
    // capture stage
    // ----

    logic st_valid_reg;
    logic st_valid_next;
    lsm_pkg::lsm_frame_in_t st_frame_reg;
    lsm_pkg::lsm_layout_t st_layout_reg;
    logic in_ready_reg;
    logic in_ready_next;
    wire take;
    wire push;
    wire fifo_wr_ready;
    wire [$clog2(`LSM_FIFO_DEPTH):0] fifo_level;
    wire lsm_pkg::lsm_lane_frame_t map_frame;

    assign take = in_valid && in_ready_reg;
    assign push = st_valid_reg && fifo_wr_ready;
    assign st_valid_next = take || (st_valid_reg && !push);
    // ready is registered, so it looks at fifo level with slack for the
    // frame in the capture stage and the one arriving this edge
    assign in_ready_next = (fifo_level
                            <= ($clog2(`LSM_FIFO_DEPTH)+1)'(`LSM_FIFO_DEPTH - `LSM_FIFO_SLACK));
    assign in_ready = in_ready_reg;

    // capture control; the layout travels with its frame so a mode
    // change never splits one frame across two layouts
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_valid_reg <= 1'b0;
            in_ready_reg <= 1'b0;
            st_layout_reg <= lsm_pkg::LSM_LAY_NONE;
        end else begin
            st_valid_reg <= st_valid_next;
            in_ready_reg <= in_ready_next;
            if (take) begin
                st_layout_reg <= mode_layout;
            end
        end
    end

    // sample payload, cleared to zero on reset like the valid flag
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_frame_reg <= '0;
        end else if (take) begin
            st_frame_reg <= in_frame;
        end
    end

    // ----
    // lane count per layout
    // ----

    wire lsm_pkg::lsm_layout_t lay = st_layout_reg;
    wire [`LSM_CNT_W-1:0] used_cnt;

    // lanes past this count in each group carry nothing
    assign used_cnt =
        (lay == lsm_pkg::LSM_LAY_8B_DUAL16) ? `LSM_N_EIGHT :
        (lay == lsm_pkg::LSM_LAY_DEC_4) ? `LSM_N_TWO :
        (lay == lsm_pkg::LSM_LAY_DEC_8) ? `LSM_N_FOUR :
        (lay == lsm_pkg::LSM_LAY_DEC_16) ? `LSM_N_EIGHT :
        (lay == lsm_pkg::LSM_LAY_DEC8_2) ? `LSM_N_ONE :
        (lay == lsm_pkg::LSM_LAY_12B_12) ? `LSM_N_SIX :
        `LSM_N_NONE;

    // ---------------------------------------------------------------
    // per-lane mapping
    // ---------------------------------------------------------------

    // both groups map the same way; only the source group differs
    for (genvar g = 0; g < 2; g++) begin : g_grp
        lsm_pkg::lsm_grp_in_t src;
        assign src = st_frame_reg.grp[g];

        for (genvar k = 0; k < `LSM_GRP_LANES; k++) begin : g_lane
            localparam int LI = g * `LSM_GRP_LANES + k;
            localparam int IX = k % `LSM_DEC_WORDS;
            localparam int Q8 = (k >= 2) ? (k - 2) % `LSM_DEC_WORDS : 0;
            localparam int TB = (k < 6) ? (k / 3) * 4 : 0;
            localparam int PS = k % 3;

            wire [`LSM_LANE_W-1:0] w_8b;
            wire [`LSM_LANE_W-1:0] w_d4;
            wire [`LSM_LANE_W-1:0] w_d8;
            wire [`LSM_LANE_W-1:0] w_d16;
            wire [`LSM_LANE_W-1:0] w_d2;
            wire [`LSM_LANE_W-1:0] w_12;
            wire [`LSM_WORD_W-1:0] pk12;
            wire [`LSM_WORD_W-1:0] iw_k;
            wire [`LSM_WORD_W-1:0] qw_0;
            wire [`LSM_WORD_W-1:0] qw_8;
            wire [`LSM_WORD_W-1:0] qw_16;
            wire [`LSM_WORD_W-1:0] iw_0;
            wire [`LSM_LANE_W-1:0] w_sel;
            wire lane_on;

            assign iw_k = lsm_dec_word(src.inph[IX], src.ovr_first[IX]);
            assign iw_0 = lsm_dec_word(src.inph[0], src.ovr_first[0]);
            assign qw_0 = lsm_dec_word(src.quad[0], src.ovr_second[0]);
            assign qw_8 = lsm_dec_word(src.quad[Q8], src.ovr_second[Q8]);
            assign qw_16 = lsm_dec_word(src.quad[IX], src.ovr_second[IX]);

            // one octet per lane, sample n on lane n
            assign w_8b = {src.smp[k][`LSM_OCT_LOW], `LSM_PAD24};
            // lane 0 in-phase, lane 1 quadrature
            assign w_d4 = (k == 0) ? {iw_0, `LSM_PAD16}
                                   : {qw_0, `LSM_PAD16};
            // lanes 0,1 in-phase words, lanes 2,3 quadrature words
            assign w_d8 = (k < 2) ? {iw_k, `LSM_PAD16}
                                  : {qw_8, `LSM_PAD16};
            // lanes 0-3 in-phase, lanes 4-7 quadrature, same index flags
            assign w_d16 = (k < 4) ? {iw_k, `LSM_PAD16}
                                   : {qw_16, `LSM_PAD16};
            // in-phase in octets 0-1, quadrature in octets 2-3
            assign w_d2 = {iw_0, qw_0};

            // four samples across three lanes, most significant part first
            assign pk12 =
                (PS == 0) ? {src.smp[TB][`LSM_SMP_W-1:0], src.smp[TB+1][`LSM_TOP4]} :
                (PS == 1) ? {src.smp[TB+1][`LSM_LOW8], src.smp[TB+2][`LSM_TOP8]} :
                {src.smp[TB+2][`LSM_LOW4], src.smp[TB+3][`LSM_SMP_W-1:0]};
            assign w_12 = {pk12, `LSM_PAD16};

            assign w_sel =
                (lay == lsm_pkg::LSM_LAY_8B_DUAL16) ? w_8b :
                (lay == lsm_pkg::LSM_LAY_DEC_4) ? w_d4 :
                (lay == lsm_pkg::LSM_LAY_DEC_8) ? w_d8 :
                (lay == lsm_pkg::LSM_LAY_DEC_16) ? w_d16 :
                (lay == lsm_pkg::LSM_LAY_DEC8_2) ? w_d2 :
                w_12;

            // unused lanes go out as zero so stale samples never leak
            assign lane_on = (`LSM_CNT_W'(k) < used_cnt);
            assign map_frame.lane[LI] = lane_on ? w_sel : '0;
            assign map_frame.lane_used[LI] = lane_on;
        end
    end

    // ---------------------------------------------------------------
    // output fifo
    // ---------------------------------------------------------------

    // the fifo absorbs link-layer stalls; its output word and valid are
    // registers inside, so the top outputs come straight from flops
    lsm_fifo #(
        .WIDTH($bits(lsm_pkg::lsm_lane_frame_t)),
        .DEPTH(`LSM_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .wr_valid(push),
        .wr_ready(fifo_wr_ready),
        .wr_data(map_frame),
        .rd_valid(out_valid),
        .rd_ready(out_ready),
        .rd_data(out_frame),
        .level(fifo_level)
    );

endmodule : lane_sample_mapper

`default_nettype wire

// ==== rtl/lsm_map.svh ====
// lane sample mapper: widths, mode numbers and fifo sizing as macros
// assumes it is included by the package and the mapper before any use
`ifndef LSM_MAP_SVH
`define LSM_MAP_SVH

// ----
// widths
// ----
`define LSM_MODE_W 7
`define LSM_SMP_W 12
`define LSM_DEC_W 15
`define LSM_OCT_W 8
`define LSM_WORD_W 16
`define LSM_LANE_W 32
`define LSM_LANES 16
`define LSM_GRP_LANES 8
`define LSM_DEC_WORDS 4
`define LSM_CNT_W 4

// ----
// twelve-bit split points, most significant part first
// ----
`define LSM_TOP4 11:8
`define LSM_LOW8 7:0
`define LSM_TOP8 11:4
`define LSM_LOW4 3:0
`define LSM_OCT_LOW 7:0

// ----
// padding and lane counts per layout (per group)
// ----
`define LSM_PAD24 24'h000000
`define LSM_PAD16 16'h0000
`define LSM_PAD20 20'h00000
`define LSM_N_NONE 4'h0
`define LSM_N_ONE 4'h1
`define LSM_N_TWO 4'h2
`define LSM_N_FOUR 4'h4
`define LSM_N_SIX 4'h6
`define LSM_N_EIGHT 4'h8

// ----
// link mode numbers
// ----
`define LSM_M8 7'h08
`define LSM_M51 7'h33
`define LSM_M10 7'h0A
`define LSM_M37 7'h25
`define LSM_M11 7'h0B
`define LSM_M47 7'h2F
`define LSM_M12 7'h0C
`define LSM_M53 7'h35
`define LSM_M13 7'h0D
`define LSM_M39 7'h27
`define LSM_M56 7'h38
`define LSM_M59 7'h3B
`define LSM_M66 7'h42
`define LSM_M68 7'h44
`define LSM_M14 7'h0E
`define LSM_M49 7'h31
`define LSM_M57 7'h39
`define LSM_M60 7'h3C
`define LSM_M67 7'h43
`define LSM_M15 7'h0F
`define LSM_M55 7'h37
`define LSM_M58 7'h3A
`define LSM_M16 7'h10
`define LSM_M19 7'h13
`define LSM_M42 7'h2A
`define LSM_M20 7'h14
`define LSM_M43 7'h2B

// ----
// fifo sizing
// ----
`define LSM_FIFO_DEPTH 32
`define LSM_FIFO_SLACK 4

`endif

// ==== rtl/lsm_pkg.sv ====
// lane sample mapper: shared types for samples in and lane words out
// assumes lsm_map.svh sits beside it on the include path
`include "lsm_map.svh"
`default_nettype none

package lsm_pkg;

    // lane layouts that the mode number selects
    typedef enum logic [3:0] {
        LSM_LAY_NONE,
        LSM_LAY_8B_DUAL16,
        LSM_LAY_DEC_4,
        LSM_LAY_DEC_8,
        LSM_LAY_DEC_16,
        LSM_LAY_DEC8_2,
        LSM_LAY_12B_12
    } lsm_layout_t;

    // one channel group worth of samples for one frame
    typedef struct packed {
        logic [`LSM_GRP_LANES-1:0][`LSM_SMP_W-1:0] smp;
        logic [`LSM_DEC_WORDS-1:0][`LSM_DEC_W-1:0] inph;
        logic [`LSM_DEC_WORDS-1:0][`LSM_DEC_W-1:0] quad;
        logic [`LSM_DEC_WORDS-1:0] ovr_first;
        logic [`LSM_DEC_WORDS-1:0] ovr_second;
    } lsm_grp_in_t;

    // index 0 is group a, index 1 is group b
    typedef struct packed {
        lsm_grp_in_t [1:0] grp;
    } lsm_frame_in_t;

    // lanes 0..7 are group a, 8..15 group b; octet 0 in the top bits
    typedef struct packed {
        logic [`LSM_LANES-1:0] lane_used;
        logic [`LSM_LANES-1:0][`LSM_LANE_W-1:0] lane;
    } lsm_lane_frame_t;

endpackage : lsm_pkg

`default_nettype wire

// ==== rtl/lsm_fifo_mem.sv ====
// lane sample mapper: simple dual-port store for the lane frame fifo
// assumes one clock; read data comes out of a register one edge after rd_en
`default_nettype none

module lsm_fifo_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);

    logic [WIDTH-1:0] store [DEPTH];

    // the array has no reset so it can map onto ram
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            store[wr_addr] <= wr_data;
        end
    end

    // registered read; holds its word until the next read
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= '0;
        end else if (rd_en) begin
            rd_data <= store[rd_addr];
        end
    end

endmodule : lsm_fifo_mem

`default_nettype wire

// ==== rtl/lsm_fifo.sv ====
// lane sample mapper: valid/ready fifo with a registered output word
// assumes one clock; the output register is an extra slot beyond DEPTH
`default_nettype none

module lsm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [WIDTH-1:0] wr_data,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [WIDTH-1:0] rd_data,
    output logic [$clog2(DEPTH):0] level
);

    localparam int AW = $clog2(DEPTH);

    logic [AW:0] wptr_reg;
    logic [AW:0] rptr_reg;
    logic ov_reg;
    wire mem_empty;
    wire mem_full;
    wire push;
    wire fetch;

    // one extra pointer bit tells full from empty
    assign mem_empty = (wptr_reg == rptr_reg);
    assign mem_full = (wptr_reg[AW] != rptr_reg[AW]) && (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
    assign wr_ready = !mem_full;
    assign push = wr_valid && !mem_full;
    // refill the output register when it is free or being drained
    assign fetch = !mem_empty && (!ov_reg || rd_ready);
    assign level = wptr_reg - rptr_reg;
    assign rd_valid = ov_reg;

    // pointers and output-valid flag
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            ov_reg <= 1'b0;
        end else begin
            wptr_reg <= wptr_reg + (AW+1)'(push);
            rptr_reg <= rptr_reg + (AW+1)'(fetch);
            ov_reg <= fetch || (ov_reg && !rd_ready);
        end
    end

    lsm_fifo_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .wr_en(push),
        .wr_addr(wptr_reg[AW-1:0]),
        .wr_data(wr_data),
        .rd_en(fetch),
        .rd_addr(rptr_reg[AW-1:0]),
        .rd_data(rd_data)
    );

endmodule : lsm_fifo

`default_nettype wire

// ==== test/lsm_checker.sv ====
// lane mapper checker: port-level assertions on the lane frame stream
// assumes it is bound to lane_sample_mapper and sees only its ports
`include "lsm_map.svh"
`default_nettype none

module lsm_checker (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [`LSM_MODE_W-1:0] link_mode_select,
    input wire logic in_valid,
    input wire logic in_ready,
    input wire lsm_pkg::lsm_frame_in_t in_frame,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire lsm_pkg::lsm_lane_frame_t out_frame
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // helper logic
    // ----
    logic [5:0] held_reg;
    logic pad_bad;
    logic low_bad;
    logic [7:0] ua;
    logic use_ok;
    wire logic take_in = in_valid && in_ready;
    wire logic take_out = out_valid && out_ready;
    assign ua = out_frame.lane_used[7:0];
    assign use_ok = (out_frame.lane_used[15:8] == ua) &&
        (ua inside {8'h00, 8'h01, 8'h03, 8'h0F, 8'h3F, 8'hFF});

    // frames taken in but not yet handed on; six bits cover fifo plus stages
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            held_reg <= 6'h00;
        end else begin
            held_reg <= held_reg + 6'(take_in) - 6'(take_out);
        end
    end

    // unused lanes must be zero; only the one-lane word fills the low half
    always_comb begin
        pad_bad = 1'b0;
        low_bad = 1'b0;
        for (int k = 0; k < `LSM_LANES; k++) begin
            if (!out_frame.lane_used[k] && out_frame.lane[k] != 32'h0) pad_bad = 1'b1;
            if (out_frame.lane[k][15:0] != 16'h0) low_bad = 1'b1;
        end
    end

    // ----
    // assertions
    // ----
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    hold_frame_a: assert property (out_valid && !out_ready |=>
        out_valid && $stable(out_frame)) else $error("lane frame changed while stalled");
    pad_zero_a: assert property (out_valid |-> !pad_bad)
        else $error("unused lane carries data");
    group_match_a: assert property (out_valid |-> use_ok)
        else $error("lane use pattern not a layout");
    low_half_a: assert property (out_valid && ua != 8'h01 |-> !low_bad)
        else $error("low half of a lane word not zero");
    first_out_a: assert property (take_in && held_reg == 6'h00 |-> ##[2:3] out_valid)
        else $error("frame late through empty pipe");
    no_phantom_a: assert property (held_reg == 6'h00 |-> !out_valid)
        else $error("output frame with nothing taken");
    no_overrun_a: assert property (held_reg <= 6'h22)
        else $error("more frames held than storage");
    ready_drop_a: assert property ($fell(in_ready) |-> held_reg >= 6'h1B)
        else $error("ready dropped with room left");

    cover property (out_valid && !out_ready);
    cover property (!in_ready);
    cover property (out_valid && ua == 8'h01);
    cover property (out_valid && ua == 8'h3F);
endmodule : lsm_checker

bind lane_sample_mapper lsm_checker u_lsm_chk (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .link_mode_select(link_mode_select),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_frame(in_frame),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_frame(out_frame)
);

`default_nettype wire

// ==== test/lsm_rx_model.sv ====
// lane mapper partner: link-layer receiver taking lane frames
// assumes one clock; stall and slow pacing come from the bench
`default_nettype none

module lsm_rx_model (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic stall,
    input wire logic slow,
    input wire logic out_valid,
    output logic out_ready,
    input wire lsm_pkg::lsm_lane_frame_t out_frame,
    output logic got,
    output lsm_pkg::lsm_lane_frame_t got_frame
);
    timeunit 1ns;
    timeprecision 1ps;
    logic phase_reg;

    // ready is low while stalled, and every other cycle when slow
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            phase_reg <= 1'b0;
            out_ready <= 1'b0;
        end else begin
            phase_reg <= !phase_reg;
            out_ready <= !stall && (!slow || phase_reg);
        end
    end

    // a frame counts only where valid meets ready; bench unpacks with its mode
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            got <= 1'b0;
            got_frame <= '0;
        end else begin
            got <= out_valid && out_ready;
            if (out_valid && out_ready) got_frame <= out_frame;
        end
    end
endmodule : lsm_rx_model

`default_nettype wire

// ==== test/lane_sample_mapper_tb.sv ====
// lane mapper bench: every mode row, back-pressure, reset in mid-run
// assumes lsm_pkg compiled first and the receiver model beside it
`include "lsm_map.svh"
`default_nettype none

module lane_sample_mapper_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [6:0] mode; logic [3:0] used;} lsm_row_t;
    localparam lsm_row_t ROWS [28] = '{
        '{`LSM_M8, 4'h8}, '{`LSM_M51, 4'h8}, '{`LSM_M10, 4'h2}, '{`LSM_M37, 4'h2},
        '{`LSM_M11, 4'h4}, '{`LSM_M47, 4'h4}, '{`LSM_M12, 4'h8}, '{`LSM_M53, 4'h8},
        '{`LSM_M13, 4'h1}, '{`LSM_M39, 4'h1}, '{`LSM_M56, 4'h1}, '{`LSM_M59, 4'h1},
        '{`LSM_M66, 4'h1}, '{`LSM_M68, 4'h1}, '{`LSM_M14, 4'h2}, '{`LSM_M49, 4'h2},
        '{`LSM_M57, 4'h2}, '{`LSM_M60, 4'h2}, '{`LSM_M67, 4'h2}, '{`LSM_M15, 4'h4},
        '{`LSM_M55, 4'h4}, '{`LSM_M58, 4'h4}, '{`LSM_M16, 4'h8}, '{`LSM_M19, 4'h6},
        '{`LSM_M42, 4'h6}, '{`LSM_M20, 4'h6}, '{`LSM_M43, 4'h6}, '{7'h7F, 4'h0}};
    logic clk_sys, arst_n, in_valid, in_ready, out_valid, out_ready, stall, slow, got;
    logic [`LSM_MODE_W-1:0] link_mode_select;
    lsm_pkg::lsm_frame_in_t in_frame;
    lsm_pkg::lsm_lane_frame_t out_frame, got_frame;
    lsm_pkg::lsm_lane_frame_t exp_q [$];
    int error_cnt = 0;
    int check_count = 0;

    lane_sample_mapper uut (.clk_sys(clk_sys), .arst_n(arst_n),
        .link_mode_select(link_mode_select), .in_valid(in_valid), .in_ready(in_ready),
        .in_frame(in_frame), .out_valid(out_valid), .out_ready(out_ready),
        .out_frame(out_frame));
    lsm_rx_model u_rx (.clk_sys(clk_sys), .arst_n(arst_n), .stall(stall), .slow(slow),
        .out_valid(out_valid), .out_ready(out_ready), .out_frame(out_frame), .got(got),
        .got_frame(got_frame));

    // ----
    // helpers
    // ----
    always #20 clk_sys = ~clk_sys;

    task automatic chk(input bit ok, input string m);
        check_count++;
        if (!ok) begin
            error_cnt++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : chk

    function automatic lsm_pkg::lsm_frame_in_t mk(int s);
        lsm_pkg::lsm_frame_in_t f;
        for (int i = 0; i < $bits(f); i++) f[i] = ((i * 13 + s * 7) % 11) > 4;
        return f;
    endfunction : mk

    // expected lanes per layout; dec words split half in-phase, half quadrature
    function automatic lsm_pkg::lsm_lane_frame_t exp_f(lsm_row_t r, lsm_pkg::lsm_frame_in_t f);
        lsm_pkg::lsm_lane_frame_t e;
        lsm_pkg::lsm_grp_in_t x;
        logic [11:0] s0, s1, s2, s3;
        int b;
        int h;
        e = '0;
        h = r.used / 2;
        for (int g = 0; g < 2; g++) begin
            x = f.grp[g];
            b = 8 * g;
            case (r.mode)
                `LSM_M8, `LSM_M51: for (int k = 0; k < 8; k++) begin
                    e.lane[b+k] = {x.smp[k][7:0], 24'h0};
                end
                `LSM_M13, `LSM_M39, `LSM_M56, `LSM_M59, `LSM_M66, `LSM_M68: begin
                    e.lane[b] = {x.inph[0], x.ovr_first[0], x.quad[0], x.ovr_second[0]};
                end
                `LSM_M19, `LSM_M42, `LSM_M20, `LSM_M43: for (int t = 0; t < 2; t++) begin
                    {s0, s1, s2, s3} = {x.smp[4*t], x.smp[4*t+1], x.smp[4*t+2], x.smp[4*t+3]};
                    e.lane[b+3*t] = {s0, s1[11:8], 16'h0};
                    e.lane[b+3*t+1] = {s1[7:0], s2[11:4], 16'h0};
                    e.lane[b+3*t+2] = {s2[3:0], s3, 16'h0};
                end
                7'h7F: ;
                default: for (int k = 0; k < h; k++) begin
                    e.lane[b+k] = {x.inph[k], x.ovr_first[k], 16'h0};
                    e.lane[b+h+k] = {x.quad[k], x.ovr_second[k], 16'h0};
                end
            endcase
            for (int k = 0; k < r.used; k++) e.lane_used[b+k] = 1'b1;
        end
        return e;
    endfunction : exp_f

    // holds valid until a ready edge; leaves valid up so beats run back to back
    task automatic send(input lsm_row_t r, input int s);
        in_valid <= 1'b1;
        in_frame <= mk(s);
        exp_q.push_back(exp_f(r, mk(s)));
        @(negedge clk_sys);
        repeat (200) if (!in_ready) @(negedge clk_sys);
        @(posedge clk_sys);
    endtask : send

    task automatic drain();
        repeat (400) if (exp_q.size() != 0) @(posedge clk_sys);
        chk(exp_q.size() == 0, "frames missing");
    endtask : drain

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    // every frame the receiver takes must match the oldest expected one
    always @(negedge clk_sys) begin
        if (arst_n && got) begin
            if (exp_q.size() == 0) chk(1'b0, "frame with none expected");
            else chk(got_frame === exp_q.pop_front(), "lane frame mismatch");
        end
    end

    // the run needs well under a thousand cycles; this cuts a hang short
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        $display("BAD %0t watchdog expired", $time);
        test_done();
    end

    // ----
    // main sequence
    // ----
    initial begin
        clk_sys = 1'b0;
        arst_n = 1'b0;
        in_valid = 1'b0;
        in_frame = '0;
        link_mode_select = '0;
        stall = 1'b0;
        slow = 1'b0;
        repeat (8) @(posedge clk_sys);
        chk(in_ready === 1'b0 && out_valid === 1'b0, "outputs live in reset");
        arst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        $display("reset test done");
        foreach (ROWS[r]) begin
            link_mode_select <= ROWS[r].mode;
            slow <= r[0];
            repeat (4) @(posedge clk_sys);
            for (int j = 0; j < 3; j++) send(ROWS[r], r * 3 + j);
            in_valid <= 1'b0;
            drain();
            $display("row %0d mode %0d done", r, ROWS[r].mode);
        end
        // stalled receiver: the fifo fills, ready drops, nothing is lost
        link_mode_select <= ROWS[8].mode;
        slow <= 1'b0;
        stall <= 1'b1;
        repeat (4) @(posedge clk_sys);
        fork
            for (int j = 0; j < 40; j++) send(ROWS[8], 100 + j);
            begin
                repeat (80) @(posedge clk_sys);
                @(negedge clk_sys);
                chk(in_ready === 1'b0, "no back-pressure");
                chk(exp_q.size() >= 29 && exp_q.size() <= 35, "fill level off");
                @(posedge clk_sys);
                stall <= 1'b0;
            end
        join
        in_valid <= 1'b0;
        drain();
        $display("back-pressure test done");
        // reset with frames stuck inside: none may come out afterwards
        stall <= 1'b1;
        link_mode_select <= ROWS[26].mode;
        repeat (4) @(posedge clk_sys);
        send(ROWS[26], 1);
        send(ROWS[26], 2);
        in_valid <= 1'b0;
        @(posedge clk_sys);
        arst_n <= 1'b0;
        exp_q.delete();
        @(negedge clk_sys);
        chk(out_valid === 1'b0 && in_ready === 1'b0, "reset did not clear");
        @(posedge clk_sys);
        stall <= 1'b0;
        arst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(in_ready === 1'b1, "not ready after reset");
        @(posedge clk_sys);
        send(ROWS[26], 3);
        in_valid <= 1'b0;
        drain();
        $display("mid-run reset test done");
        test_done();
    end
endmodule : lane_sample_mapper_tb

`default_nettype wire
